/* File: fbc_pkg.sv */
package fbc_pkg;
    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [4:0] SYM_SSD1 = 5'h18;
    localparam logic [4:0] SYM_SSD2 = 5'h11;
    localparam logic [4:0] SYM_ESD1 = 5'h0D;
    localparam logic [4:0] SYM_ESD2 = 5'h07;
    localparam logic [4:0] SYM_TXERR = 5'h04;
    localparam logic [3:0] NIB_SSD = 4'h5;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [2:0] {TX_IDLE, TX_SSD1, TX_SSD2, TX_DATA, TX_ESD1, TX_ESD2} fbc_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_SSD, RX_FRAME, RX_ESD} fbc_rx_state_t;
endpackage : fbc_pkg

/* File: fbc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module fbc_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] PTR_STEP = {{AW{1'b0}}, 1'b1};
    // the wrap bit only tells full from empty when the depth is a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fbc_fifo: DEPTH must be a power of two of at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("fbc_fifo: WIDTH must be at least 1");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire do_wr = in_valid && !full;
    wire do_rd = out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge clk) begin
        if (do_wr) mem[wr_ptr[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) wr_ptr <= wr_ptr + PTR_STEP;
            if (do_rd) rd_ptr <= rd_ptr + PTR_STEP;
        end
    end
endmodule : fbc_fifo
`default_nettype wire

/* File: fbc_codec.sv */
`timescale 1ns/1ps
`default_nettype none
module fbc_codec
    import fbc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // transmit nibbles from mac
    input wire logic tx_en,
    input wire logic tx_er,
    input wire logic [3:0] tx_nib,
    // transmit code groups toward line, one per symbol enable
    input wire logic sym_en,
    output logic [4:0] tx_sym,
    output logic tx_sym_valid,
    output logic tx_overflow,
    // receive code groups from line
    input wire logic rx_sym_valid,
    input wire logic [4:0] rx_sym,
    // receive nibbles toward mac
    output logic rx_dv,
    output logic rx_er,
    output logic [3:0] rx_nib,
    output logic rx_start,
    output logic rx_end,
    output logic rx_idle
);
    // code group of each data nibble, indexed by the nibble; one table serves both directions
    localparam logic [4:0] ENC_TABLE [16] = '{
        5'h1E, 5'h09, 5'h14, 5'h15,
        5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17,
        5'h1A, 5'h1B, 5'h1C, 5'h1D
    };

    // ---------------- transmit ----------------
    // mac nibbles are pushed into the fifo with a flag bit for tx_er and a
    // frame-end marker; the symbol side drains it at the symbol rate
    // word layout: bit 5 end marker, bit 4 transmit error, bits 3..0 nibble
    logic tx_en_d;
    logic end_pending;
    wire frame_end = tx_en_d && !tx_en;
    // an end marker refused by a full fifo is held back, else the frame would never close
    wire want_end = frame_end || end_pending;
    wire [5:0] push_word = want_end ? 6'h20 : {1'b0, tx_er, tx_nib};
    wire push = tx_en || want_end;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [5:0] fifo_out;
    fbc_tx_state_t tx_state;
    fbc_tx_state_t next_tx_state;
    logic [4:0] next_tx_sym;
    logic pop;
    // the fifo is only drained on symbol times, whatever the pacing
    wire fifo_pop = pop && sym_en;

    fbc_fifo #(.WIDTH(6), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    wire head_is_end = fifo_out[5];
    wire [4:0] data_sym = fifo_out[4] ? SYM_TXERR : ENC_TABLE[fifo_out[3:0]];

    always_comb begin
        next_tx_state = tx_state;
        next_tx_sym = SYM_IDLE;
        pop = 1'b0;
        case (tx_state)
            TX_IDLE: begin
                if (fifo_out_valid && !head_is_end) begin
                    next_tx_sym = SYM_SSD1;
                    next_tx_state = TX_SSD1;
                end else begin
                    pop = fifo_out_valid;
                end
            end
            TX_SSD1: begin
                next_tx_sym = SYM_SSD2;
                next_tx_state = TX_DATA;
            end
            TX_DATA, TX_SSD2: begin
                if (fifo_out_valid && head_is_end) begin
                    pop = 1'b1;
                    next_tx_sym = SYM_ESD1;
                    next_tx_state = TX_ESD1;
                end else if (fifo_out_valid) begin
                    pop = 1'b1;
                    next_tx_sym = data_sym;
                end else begin
                    // underrun: mark the frame broken rather than stall the line
                    next_tx_sym = SYM_TXERR;
                end
            end
            TX_ESD1: begin
                next_tx_sym = SYM_ESD2;
                next_tx_state = TX_IDLE;
            end
            default: begin
                next_tx_state = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_en_d <= 1'b0;
            end_pending <= 1'b0;
            tx_state <= TX_IDLE;
            tx_sym <= SYM_IDLE;
            tx_sym_valid <= 1'b0;
            tx_overflow <= 1'b0;
        end else begin
            tx_en_d <= tx_en;
            end_pending <= want_end && !fifo_in_ready;
            tx_overflow <= push && !fifo_in_ready;
            tx_sym_valid <= sym_en;
            if (sym_en) begin
                tx_state <= next_tx_state;
                tx_sym <= next_tx_sym;
            end
        end
    end

    // ---------------- receive ----------------
    fbc_rx_state_t rx_state;
    // one comparator per data group; a group that hits none is not data
    wire [15:0] rx_hit;
    for (genvar gi = 0; gi < 16; gi++) begin : g_dec
        assign rx_hit[gi] = (rx_sym == ENC_TABLE[gi]);
    end
    wire rx_is_data = |rx_hit;
    wire [3:0] rx_dec_nib = {|(rx_hit & 16'hFF00), |(rx_hit & 16'hF0F0), |(rx_hit & 16'hCCCC), |(rx_hit & 16'hAAAA)};
    wire rx_is_ssd1 = (rx_sym == SYM_SSD1);
    wire rx_is_ssd2 = (rx_sym == SYM_SSD2);
    wire rx_is_esd1 = (rx_sym == SYM_ESD1);
    wire rx_is_esd2 = (rx_sym == SYM_ESD2);
    wire rx_is_idle = (rx_sym == SYM_IDLE);
    wire rx_is_txerr = (rx_sym == SYM_TXERR);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state <= RX_IDLE;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rx_nib <= 4'h0;
            rx_start <= 1'b0;
            rx_end <= 1'b0;
            rx_idle <= 1'b1;
        end else if (rx_sym_valid) begin
            rx_start <= 1'b0;
            rx_end <= 1'b0;
            rx_er <= 1'b0;
            rx_idle <= rx_is_idle;
            case (rx_state)
                RX_IDLE: begin
                    rx_dv <= 1'b0;
                    if (rx_is_ssd1) rx_state <= RX_SSD;
                end
                RX_SSD: begin
                    if (rx_is_ssd2) begin
                        rx_state <= RX_FRAME;
                        rx_start <= 1'b1;
                        rx_dv <= 1'b1;
                        rx_nib <= NIB_SSD;
                    end else begin
                        rx_state <= rx_is_ssd1 ? RX_SSD : RX_IDLE;
                    end
                end
                RX_FRAME: begin
                    if (rx_is_esd1) begin
                        rx_state <= RX_ESD;
                        rx_dv <= 1'b0;
                    end else if (rx_is_idle) begin
                        // frame lost its delimiter: close it with an error
                        rx_state <= RX_IDLE;
                        rx_dv <= 1'b0;
                        rx_er <= 1'b1;
                    end else begin
                        rx_dv <= 1'b1;
                        rx_nib <= rx_dec_nib;
                        rx_er <= !rx_is_data;
                    end
                end
                RX_ESD: begin
                    rx_state <= RX_IDLE;
                    rx_end <= rx_is_esd2;
                    rx_er <= !rx_is_esd2;
                end
                default: rx_state <= RX_IDLE;
            endcase
        end else begin
            rx_start <= 1'b0;
            rx_end <= 1'b0;
        end
    end

    property p_never_invalid;
        @(posedge clk) disable iff (rst)
        !(tx_sym inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19});
    endproperty
    a_never_invalid: assert property (p_never_invalid) else $error("encoder sent invalid group");

    property p_ssd_pair;
        @(posedge clk) disable iff (rst)
        (sym_en && tx_state == TX_SSD1) |=> (tx_sym == SYM_SSD2) && $past(tx_sym) == SYM_SSD1;
    endproperty
    a_ssd_pair: assert property (p_ssd_pair) else $error("start delimiter pair broken");

    property p_esd_pair;
        @(posedge clk) disable iff (rst)
        (sym_en && tx_state == TX_ESD1) |=> tx_sym == SYM_ESD2 && tx_state == TX_IDLE;
    endproperty
    a_esd_pair: assert property (p_esd_pair) else $error("end delimiter pair broken");

    property p_idle_out;
        @(posedge clk) disable iff (rst)
        (sym_en && tx_state == TX_IDLE && !fifo_out_valid) |=> tx_sym == SYM_IDLE;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("idle not sent between frames");

    property p_rx_invalid;
        @(posedge clk) disable iff (rst)
        (rx_sym_valid && rx_state == RX_FRAME && !rx_is_data && !rx_is_esd1 && !rx_is_idle) |=> rx_er;
    endproperty
    a_rx_invalid: assert property (p_rx_invalid) else $error("invalid group in frame without error");

    property p_rx_data;
        @(posedge clk) disable iff (rst)
        (rx_sym_valid && rx_state == RX_FRAME && rx_sym == 5'h1E) |=> rx_dv && rx_nib == 4'h0 && !rx_er;
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("data zero misdecoded");

    property p_rx_start;
        @(posedge clk) disable iff (rst)
        (rx_sym_valid && rx_state == RX_SSD && rx_is_ssd2) |=> rx_start && rx_nib == NIB_SSD;
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("frame start missed");

    property p_tx_err;
        @(posedge clk) disable iff (rst)
        (sym_en && tx_state == TX_DATA && fifo_out_valid && !fifo_out[5] && fifo_out[4]) |=> tx_sym == SYM_TXERR;
    endproperty
    a_tx_err: assert property (p_tx_err) else $error("transmit error not substituted");
endmodule : fbc_codec
`default_nettype wire

/* File: fbc_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fbc_line_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pacing and mode
    input wire logic slow,
    input wire logic loop,
    // transmit side of the codec
    output logic sym_en,
    input wire logic [4:0] tx_sym,
    input wire logic tx_sym_valid,
    // symbols injected by the bench
    input wire logic inj_valid,
    input wire logic [4:0] inj_sym,
    // receive side of the codec
    output logic rx_sym_valid,
    output logic [4:0] rx_sym
);
    logic phase;
    // slow pacing halves the symbol rate so the mac side outruns the fifo
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase <= 1'b0;
            sym_en <= 1'b0;
            rx_sym_valid <= 1'b0;
            rx_sym <= 5'h00;
        end else begin
            phase <= ~phase;
            sym_en <= !slow || phase;
            rx_sym_valid <= loop ? tx_sym_valid : inj_valid;
            if (loop && tx_sym_valid) begin
                rx_sym <= tx_sym;
            end else if (!loop && inj_valid) begin
                rx_sym <= inj_sym;
            end else begin
                // between valid strobes the held symbol is inverted on every clock
                rx_sym <= ~rx_sym;
            end
        end
    end
endmodule : fbc_line_model
`default_nettype wire

/* File: test_fourb_fiveb_codec.sv */
`timescale 1ns/1ps
`default_nettype none
module test_fourb_fiveb_codec;
    import fbc_pkg::*;
    localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic clk = 1'b0, rst = 1'b1, tx_en = 1'b0, tx_er = 1'b0, slow = 1'b0, loop = 1'b1, inj_valid = 1'b0;
    logic [3:0] tx_nib = 4'h0;
    logic [4:0] inj_sym = 5'h1F;
    logic sym_en, tx_sym_valid, tx_overflow, rx_sym_valid, rx_dv, rx_er, rx_start, rx_end, rx_idle;
    logic [4:0] tx_sym, rx_sym;
    wire unused_grp = tx_sym inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19};
    logic [3:0] rx_nib;
    logic [4:0] txq [$];
    logic [3:0] rxq [$];
    int n_errors = 0, check_count = 0, n_start = 0, n_end = 0, n_er = 0, n_ovf = 0;
    always #12.5 clk = ~clk;
    fbc_codec dut (.clk(clk), .rst(rst), .tx_en(tx_en), .tx_er(tx_er), .tx_nib(tx_nib), .sym_en(sym_en),
        .tx_sym(tx_sym), .tx_sym_valid(tx_sym_valid), .tx_overflow(tx_overflow), .rx_sym_valid(rx_sym_valid),
        .rx_sym(rx_sym), .rx_dv(rx_dv), .rx_er(rx_er), .rx_nib(rx_nib), .rx_start(rx_start), .rx_end(rx_end),
        .rx_idle(rx_idle));
    fbc_line_model partner (.clk(clk), .rst(rst), .slow(slow), .loop(loop), .sym_en(sym_en), .tx_sym(tx_sym),
        .tx_sym_valid(tx_sym_valid), .inj_valid(inj_valid), .inj_sym(inj_sym), .rx_sym_valid(rx_sym_valid),
        .rx_sym(rx_sym));
    task automatic chk_sym(input logic [4:0] got, input logic [4:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_sym
    task automatic chk_cnt(input int got, input int exp, input string what);
        check_count++;
        if (got != exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk_cnt
    // everything the codec emits is logged; an unused code group is flagged at once
    always @(negedge clk) begin
        if (tx_sym_valid === 1'b1) begin
            txq.push_back(tx_sym);
            chk_sym({4'h0, unused_grp}, 5'h00, "unused code group sent");
        end
        // the start nibble is preamble, not payload
        if (rx_dv === 1'b1 && rx_start !== 1'b1) rxq.push_back(rx_nib);
        if (rx_start === 1'b1) begin
            n_start++;
            chk_sym({1'b0, rx_nib}, 5'h05, "start nibble");
        end
        if (rx_end === 1'b1) n_end++;
        if (rx_er === 1'b1) n_er++;
        if (tx_overflow === 1'b1) n_ovf++;
    end
    task automatic t_reset();
        @(posedge clk);
        chk_sym(tx_sym, 5'h1F, "idle in reset");
        chk_sym({4'h0, rx_idle}, 5'h01, "rx idle in reset");
        chk_sym({3'h0, tx_sym_valid, rx_dv}, 5'h00, "valids in reset");
    endtask : t_reset
    task automatic frame(input int n, input int er_at);
        txq.delete();
        rxq.delete();
        n_start = 0;
        n_end = 0;
        n_er = 0;
        n_ovf = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            tx_en <= 1'b1;
            tx_nib <= 4'(i);
            tx_er <= (i == er_at);
        end
        @(posedge clk);
        tx_en <= 1'b0;
        tx_er <= 1'b0;
        repeat (40) @(posedge clk);
        while (txq.size() > 0 && txq[0] === 5'h1F) void'(txq.pop_front());
    endtask : frame
    task automatic t_all_nibbles();
        frame(16, -1);
        chk_cnt(int'(txq.size() >= 21), 1, "frame length");
        chk_sym(txq[0], 5'h18, "start part 1");
        chk_sym(txq[1], 5'h11, "start part 2");
        for (int i = 0; i < 16; i++) chk_sym(txq[i + 2], ENC[i], "data code");
        chk_sym(txq[18], 5'h0D, "end part 1");
        chk_sym(txq[19], 5'h07, "end part 2");
        chk_sym(txq[20], 5'h1F, "idle after frame");
        chk_cnt(rxq.size(), 16, "decoded count");
        for (int i = 0; i < 16; i++) chk_sym({1'b0, rxq[i]}, 5'(i), "decoded nibble");
        chk_cnt(n_start, 1, "start seen");
        chk_cnt(n_end, 1, "end seen");
        chk_cnt(n_er, 0, "no error");
        chk_cnt(n_ovf, 0, "no overflow at line rate");
        chk_sym({4'h0, rx_idle}, 5'h01, "rx idle after frame");
    endtask : t_all_nibbles
    task automatic t_tx_error();
        frame(6, 3);
        chk_sym(txq[5], 5'h04, "error code sent");
        chk_cnt(n_er, 1, "error decoded");
    endtask : t_tx_error
    task automatic send(input logic [4:0] s);
        @(posedge clk);
        inj_valid <= 1'b1;
        inj_sym <= s;
    endtask : send
    task automatic t_invalid();
        logic [4:0] seq [17] = '{5'h18, 5'h11, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C,
                                 5'h10, 5'h19, 5'h04, 5'h0D, 5'h07, 5'h1F, 5'h1F};
        n_start = 0;
        n_end = 0;
        n_er = 0;
        @(posedge clk);
        loop <= 1'b0;
        foreach (seq[i]) send(seq[i]);
        @(posedge clk);
        inj_valid <= 1'b0;
        repeat (4) @(posedge clk);
        chk_cnt(n_er, 11, "invalid and error groups");
        chk_cnt(n_start, 1, "start detected");
        chk_cnt(n_end, 1, "end detected");
        chk_sym({4'h0, rx_idle}, 5'h01, "idle detected");
        loop <= 1'b1;
    endtask : t_invalid
    task automatic t_overflow();
        @(posedge clk);
        slow <= 1'b1;
        frame(12, -1);
        chk_cnt(int'(n_ovf > 0), 1, "overflow reported");
        chk_sym(tx_sym, 5'h1F, "idle after cut frame");
        slow <= 1'b0;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        rst <= 1'b0;
    endtask : t_overflow
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    initial begin
        repeat (3) @(posedge clk);
        t_reset();
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_all_nibbles();
        t_tx_error();
        t_invalid();
        t_overflow();
        conclude();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule : test_fourb_fiveb_codec
`default_nettype wire
